// *** verification/plcm_ctrl_model.sv ***
`timescale 1ns/100ps
module plcm_ctrl_model #(
  parameter int DLY   = 3,
  parameter int LIMIT = 5000
) (
  // Clock and reset.
  input  logic        clk,
  input  logic        rst,
  // Bench controls.
  input  logic        rx_en,
  input  logic        slow,
  input  logic [15:0] rx_per,
  // Link side.
  input  logic        tx_req,
  output logic        rx_frame,
  output logic        tx_done,
  output logic        late
);
  int d_cnt;
  int r_cnt;
  int g_cnt;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      {rx_frame, tx_done, late} <= 3'h0;
      d_cnt <= 0;
      r_cnt <= 0;
      g_cnt <= 0;
    end else begin
      d_cnt <= (tx_req && !tx_done) ? d_cnt + 1 : 0;
      tx_done <= tx_req && !tx_done && d_cnt >= (slow ? 8 * DLY : DLY);
      r_cnt <= (rx_en && r_cnt < rx_per) ? r_cnt + 1 : 0;
      rx_frame <= rx_en && r_cnt == rx_per;
      g_cnt <= tx_done ? 0 : g_cnt + 1;
      late <= late || g_cnt > LIMIT;
    end
  end
endmodule

// *** verification/plcm_messenger_props.sv ***
`timescale 1ns/100ps
module plcm_messenger_props #(
  parameter int CYC_PER_MS = 10
) (
  // Watched ports.
  input logic       CLK,
  input logic       RST,
  input logic [7:0] CONFIG_SWITCH_BANK,
  input logic       KEY_PRESSED,
  input logic       RX_FRAME,
  input logic       TX_REQ,
  input logic       TX_IS_REPLY,
  input logic       TX_DONE,
  input logic       BAUD_FAST,
  input logic [3:0] STATION_ADDR,
  input logic       CUSTOMER_VARIANT,
  input logic       COMM_FAULT
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  // A held key stops cyclic frames, so the gap restarts while it is down.
  logic [15:0] gap_reg;
  logic [15:0] gap_next;
  always_comb begin
    gap_next = (TX_REQ || KEY_PRESSED) ? 16'h0 : gap_reg + 16'h1;
  end
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      gap_reg <= 16'h0;
    end else begin
      gap_reg <= gap_next;
    end
  end
  a_baud_follow: assert property ($stable(CONFIG_SWITCH_BANK) [*6] |->
    BAUD_FAST == CONFIG_SWITCH_BANK[0]) else $error("line rate wrong");
  a_addr_follow: assert property ($stable(CONFIG_SWITCH_BANK) [*6] |->
    STATION_ADDR == CONFIG_SWITCH_BANK[6:3]) else $error("address wrong");
  a_variant_follow: assert property ($stable(CONFIG_SWITCH_BANK) [*6] |->
    CUSTOMER_VARIANT == CONFIG_SWITCH_BANK[7]) else $error("variant wrong");
  a_req_holds: assert property (TX_REQ && !TX_DONE |=> TX_REQ) else $error("request dropped");
  a_req_drops: assert property (TX_REQ && TX_DONE |=> !TX_REQ) else $error("request stuck");
  a_reply_prompt: assert property (RX_FRAME && !TX_REQ |-> ##[1:40] (TX_REQ && TX_IS_REPLY))
    else $error("no reply");
  a_frame_spacing: assert property (gap_reg <= 500 * CYC_PER_MS + 4) else $error("frame gap too long");
  a_fault_clear: assert property (RX_FRAME |-> ##[1:2] !COMM_FAULT) else $error("fault not cleared");
  c_fault: cover property ($rose(COMM_FAULT));
  c_reply: cover property ($rose(TX_REQ) && TX_IS_REPLY);
  c_cyclic: cover property ($rose(TX_REQ) && !TX_IS_REPLY);
endmodule
bind plcm_messenger plcm_messenger_props #(.CYC_PER_MS(CYC_PER_MS)) props_u (.CLK(CLK), .RST(RST),
  .CONFIG_SWITCH_BANK(CONFIG_SWITCH_BANK), .KEY_PRESSED(KEY_PRESSED), .RX_FRAME(RX_FRAME), .TX_REQ(TX_REQ),
  .TX_IS_REPLY(TX_IS_REPLY), .TX_DONE(TX_DONE), .BAUD_FAST(BAUD_FAST), .STATION_ADDR(STATION_ADDR),
  .CUSTOMER_VARIANT(CUSTOMER_VARIANT), .COMM_FAULT(COMM_FAULT));

// *** verification/plcm_messenger_tb_top.sv ***
`timescale 1ns/100ps
module plcm_messenger_tb_top;
  localparam int CPM = 10;
  logic        clk = 1'b0, rst = 1'b1, key = 1'b0, rx_en = 1'b0, slow = 1'b0, rx_b = 1'b0;
  logic        a_rd = 1'b0, a_wr = 1'b0, tx_prev = 1'b0;
  logic        rx, tx_req, tx_rep, tx_done, baud, vnt, fault, late, irq, wreq;
  logic [7:0]  sw = 8'hb5;
  logic [4:0]  a_ad = 5'h0;
  logic [3:0]  adr;
  logic [31:0] a_wd = 32'h0, a_rdat, rd;
  logic [1:0]  a_rsp, rs;
  int          error_cnt = 0, n_compared = 0, tick = 0, n_tx = 0, n_rep = 0, t_tx = 0;
  plcm_messenger #(.CYC_PER_MS(CPM)) dut_u (.CLK(clk), .RST(rst), .CONFIG_SWITCH_BANK(sw), .KEY_PRESSED(key),
    .RX_FRAME(rx | rx_b), .TX_REQ(tx_req), .TX_IS_REPLY(tx_rep), .TX_DONE(tx_done), .BAUD_FAST(baud),
    .STATION_ADDR(adr), .CUSTOMER_VARIANT(vnt), .COMM_FAULT(fault), .AVS_ADDRESS(a_ad), .AVS_READ(a_rd),
    .AVS_WRITE(a_wr), .AVS_WRITEDATA(a_wd), .AVS_BYTEENABLE(4'hf), .AVS_READDATA(a_rdat),
    .AVS_WAITREQUEST(wreq), .AVS_RESPONSE(a_rsp), .IRQ(irq));
  plcm_ctrl_model #(.DLY(3), .LIMIT(500 * CPM)) ctrl_u (.clk(clk), .rst(rst), .rx_en(rx_en), .slow(slow),
    .rx_per(16'h012c), .tx_req(tx_req), .rx_frame(rx), .tx_done(tx_done), .late(late));
  always #5 clk = ~clk;
  always @(posedge clk) begin
    tick <= tick + 1;
    tx_prev <= tx_req;
    if (tx_req === 1'b1 && tx_prev === 1'b0) begin
      n_tx <= n_tx + 1;
      n_rep <= n_rep + (tx_rep === 1'b1 ? 1 : 0);
      t_tx <= tick;
    end
    if (tick == 90000) begin
      error_cnt = error_cnt + 1;
      report_and_stop();
    end
  end
  task automatic chk(input string what, input logic [31:0] lo, input logic [31:0] hi, input logic [31:0] got);
    n_compared++;
    if (((got >= lo) && (got <= hi)) !== 1'b1) begin
      error_cnt++;
      $display("[FAIL] %s expected %0h..%0h seen %0h", what, lo, hi, got);
    end
  endtask
  task automatic bus(input logic w, input logic [4:0] ad, input logic [31:0] wd);
    @(posedge clk);
    a_ad <= ad;
    a_wd <= wd;
    a_wr <= w;
    a_rd <= !w;
    do @(posedge clk); while (wreq !== 1'b0);
    rd = a_rdat;
    rs = a_rsp;
    a_wr <= 1'b0;
    a_rd <= 1'b0;
  endtask
  task automatic wait_n(input int k);
    while (n_tx < k) @(posedge clk);
  endtask
  task automatic rx_pulse;
    @(posedge clk);
    rx_b <= 1'b1;
    @(posedge clk);
    rx_b <= 1'b0;
  endtask
  task automatic t_cfg(input logic [7:0] p);
    sw <= p;
    repeat (8) @(posedge clk);
    chk("baud", p[0], p[0], baud);
    chk("address", p[6:3], p[6:3], adr);
    chk("variant", p[7], p[7], vnt);
    bus(1'b0, 5'h00, 32'h0);
    chk("config reg", p, p, rd);
    $display("config %h done", p);
  endtask
  task automatic t_cycle(input logic [1:0] s, input int ms);
    int n0;
    int t0;
    sw <= {sw[7:3], s, sw[0]};
    n0 = n_tx;
    wait_n(n0 + 2);
    @(posedge clk);
    t0 = t_tx;
    wait_n(n0 + 3);
    @(posedge clk);
    chk("cycle gap", ms * CPM, ms * CPM + 12, t_tx - t0);
    $display("cycle %0d done", ms);
  endtask
  task automatic t_key;
    int n0;
    key <= 1'b1;
    repeat (2) @(posedge clk);
    n0 = n_tx;
    repeat (1500) @(posedge clk);
    chk("tx while key", n0, n0, n_tx);
    key <= 1'b0;
    repeat (520) @(posedge clk);
    chk("tx after key", n0 + 1, n0 + 1, n_tx);
    $display("key done");
  endtask
  task automatic t_fault(input logic [1:0] s, input int mon);
    int n0;
    sw <= {sw[7:3], s, sw[0]};
    repeat (8) @(posedge clk);
    n0 = n_rep;
    rx_pulse();
    repeat (mon * CPM - 20) @(posedge clk);
    chk("fault early", 0, 0, fault);
    chk("reply", n0 + 1, n0 + 1, n_rep);
    repeat (40) @(posedge clk);
    chk("fault late", 1, 1, fault);
    rx_pulse();
    repeat (3) @(posedge clk);
    chk("fault clear", 0, 0, fault);
    $display("fault %0d done", mon);
  endtask
  task automatic t_regular;
    int n0;
    slow <= 1'b1;
    rx_en <= 1'b1;
    n0 = n_rep;
    repeat (3005) @(posedge clk);
    rx_en <= 1'b0;
    repeat (60) @(posedge clk);
    chk("replies", n0 + 9, n0 + 10, n_rep);
    chk("no fault", 0, 0, fault);
    slow <= 1'b0;
    $display("regular done");
  endtask
  task automatic t_irq;
    bus(1'b0, 5'h0c, 32'h0);
    chk("mask reset", 0, 0, rd);
    bus(1'b0, 5'h10, 32'h0);
    chk("control reset", 0, 0, rd);
    bus(1'b1, 5'h0c, 32'h0);
    repeat (2) @(posedge clk);
    chk("irq masked", 0, 0, irq);
    bus(1'b1, 5'h0c, 32'h2);
    repeat (2) @(posedge clk);
    chk("irq raised", 1, 1, irq);
    bus(1'b1, 5'h08, 32'h2);
    repeat (2) @(posedge clk);
    chk("irq cleared", 0, 0, irq);
    bus(1'b0, 5'h14, 32'h0);
    chk("unmapped rsp", 2, 2, rs);
    chk("unmapped data", 0, 0, rd);
    $display("irq done");
  endtask
  task automatic report_and_stop;
    $display("compared %0d mismatched %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    t_cfg(8'hb5);
    t_cfg(8'hb4);
    t_cfg(8'h4a);
    t_cycle(2'h1, 200);
    t_cycle(2'h2, 100);
    t_cycle(2'h0, 50);
    t_key();
    t_fault(2'h0, 600);
    t_fault(2'h2, 1200);
    t_fault(2'h1, 2400);
    t_regular();
    t_irq();
    chk("controller late", 0, 0, late);
    report_and_stop();
  end
endmodule

// *** verilog/plcm_cfg_if.sv ***
`timescale 1ns/100ps
interface plcm_cfg_if;
  logic       baud_fast;
  logic [1:0] cyc_sel;
  logic [3:0] station_addr;
  logic       customer_variant;
  modport src (output baud_fast, output cyc_sel, output station_addr, output customer_variant);
  modport dst (input baud_fast, input cyc_sel, input station_addr, input customer_variant);
endinterface

// *** verilog/plcm_consts.svh ***
`ifndef PLCM_CONSTS_SVH
`define PLCM_CONSTS_SVH

// Avalon register offsets (byte addresses, word aligned).
`define PLCM_OFS_CONFIG   5'h00
`define PLCM_OFS_STATUS   5'h04
`define PLCM_OFS_IRQ_STAT 5'h08
`define PLCM_OFS_IRQ_MASK 5'h0c
`define PLCM_OFS_CONTROL  5'h10

// Switch bank positions, counted from zero for switch 1.
`define PLCM_SW_BAUD      0
`define PLCM_SW_CYC_LO    1
`define PLCM_SW_CYC_HI    2
`define PLCM_SW_ADDR_LSB  3
`define PLCM_SW_VARIANT   7

// Interrupt status bit positions and width.
`define PLCM_IRQ_FAULT_SET 0
`define PLCM_IRQ_FAULT_CLR 1
`define PLCM_IRQ_TX        2
`define PLCM_IRQ_W         3

// Times in milliseconds, then the clock in MHz and cycles per millisecond.
`define PLCM_CYC_200_MS    200
`define PLCM_CYC_100_MS    100
`define PLCM_CYC_50_MS     50
`define PLCM_MON_2400_MS   2400
`define PLCM_MON_1200_MS   1200
`define PLCM_MON_600_MS    600
`define PLCM_MAX_SPACE_MS  500
`define PLCM_CLK_MHZ       100
`define PLCM_CYC_PER_MS    (`PLCM_CLK_MHZ * 1000)

// Line rates in baud.
`define PLCM_BAUD_FAST     1500000
`define PLCM_BAUD_SLOW     187500

// Reset values of software controls.
`define PLCM_CONTROL_RST   2'h0
`define PLCM_MASK_RST      3'h0

`endif

// *** verilog/plcm_messenger.sv ***
// Overview of operation
// [RQ1] Switch 1 on picks 1.5 Mbaud, off picks 187.5 kbaud.
// [RQ2] Switches 2/3 pick cycle: 2 on 200 ms, 3 on 100 ms, both off 50 ms.
// [RQ3] Receipt timeout is 2400, 1200 or 600 ms following the cycle.
// [RQ4] With no key pressed a frame is still sent every cycle; the code sends none while control_reg[1] is set.
// [RQ5] Frames leave at least every 500 ms; a held key stops cyclic frames and control_reg[1] stops all frames.
// [RQ6] Every received frame is answered; while control_reg[1] is set no reply is sent and a pending one is dropped.
// [RQ7] Switches 4 to 7 give the station address 0 to 15.
// [RQ8] Switch 8 on picks the customer panel variant, off standard hardware.
// [RQ9] Default bank is on,off,on,off,on,on,off,on: 1.5 Mbaud, 100 ms, address 6.
// [RQ10] Smaller controller default differs only by switch 1 off.
// [RQ11] Address 6 is standard; another must match the controller block.
// [RQ12] A longer cycle lowers the controller's load.
// [RQ13] Address is binary, on is one, switch 4 is the least significant.
// [RQ14] No frame within the timeout raises a fault; a frame clears it.
`timescale 1ns/100ps
`include "plcm_consts.svh"
module plcm_messenger #(
  parameter int CYC_PER_MS = `PLCM_CYC_PER_MS
) (
  // Clock and reset.
  input  wire logic        CLK,
  input  wire logic        RST,
  // Configuration switch bank, bit 0 is switch 1, high is on.
  input  wire logic [7:0]  CONFIG_SWITCH_BANK,
  // Link side events.
  input  wire logic        KEY_PRESSED,
  input  wire logic        RX_FRAME,
  output logic             TX_REQ,
  output logic             TX_IS_REPLY,
  input  wire logic        TX_DONE,
  // Link configuration and fault status out.
  output logic             BAUD_FAST,
  output logic [3:0]       STATION_ADDR,
  output logic             CUSTOMER_VARIANT,
  output logic             COMM_FAULT,
  // Avalon-MM slave.
  input  wire logic [4:0]  AVS_ADDRESS,
  input  wire logic        AVS_READ,
  input  wire logic        AVS_WRITE,
  input  wire logic [31:0] AVS_WRITEDATA,
  input  wire logic [3:0]  AVS_BYTEENABLE,
  output logic [31:0]      AVS_READDATA,
  output logic             AVS_WAITREQUEST,
  output logic [1:0]       AVS_RESPONSE,
  // Interrupt.
  output logic             IRQ
);
  initial begin
    if (CYC_PER_MS < 1) $error("CYC_PER_MS must be positive");
  end

  localparam int CW = 32;
  localparam logic [CW-1:0] T50   = CW'(`PLCM_CYC_50_MS * CYC_PER_MS);
  localparam logic [CW-1:0] T100  = CW'(`PLCM_CYC_100_MS * CYC_PER_MS);
  localparam logic [CW-1:0] T200  = CW'(`PLCM_CYC_200_MS * CYC_PER_MS);
  localparam logic [CW-1:0] M600  = CW'(`PLCM_MON_600_MS * CYC_PER_MS);
  localparam logic [CW-1:0] M1200 = CW'(`PLCM_MON_1200_MS * CYC_PER_MS);
  localparam logic [CW-1:0] M2400 = CW'(`PLCM_MON_2400_MS * CYC_PER_MS);
  localparam logic [CW-1:0] TMAX  = CW'(`PLCM_MAX_SPACE_MS * CYC_PER_MS);

  plcm_cfg_if cfg ();

  plcm_switch_sync #(.W(8)) u_sync (
    .clk    (CLK),
    .rst    (RST),
    .sw_raw (CONFIG_SWITCH_BANK),
    .cfg    (cfg.src)
  );

  // Raw link events come from logic on the same clock.
  logic          key_s, rx_s;
  assign key_s = KEY_PRESSED;
  assign rx_s  = RX_FRAME;

  plcm_pkg::plcm_cyc_e cyc;
  logic [CW-1:0] cyc_len, mon_len, period;
  logic [1:0]    control_reg, control_next;

  always_comb begin
    cyc = plcm_pkg::plcm_cyc_e'(cfg.cyc_sel);
    case (cyc)
      plcm_pkg::PLCM_CYC_200: begin
        cyc_len = T200; // RQ2
        mon_len = M2400; // RQ3
      end
      plcm_pkg::PLCM_CYC_100: begin
        cyc_len = T100; // RQ2
        mon_len = M1200; // RQ3
      end
      plcm_pkg::PLCM_CYC_50: begin
        cyc_len = T50; // RQ2
        mon_len = M600; // RQ3
      end
      default: begin
        // Both switches on is not a listed setting; the fastest cycle keeps spacing safe.
        cyc_len = T50;
        mon_len = M600;
      end
    endcase
    // The cycle never exceeds the controller's 500 ms limit.
    period = (cyc_len > TMAX) ? TMAX : cyc_len; // RQ5
  end

  // Transmit scheduler: idle, cyclic send, reply send.
  typedef enum logic [1:0] {
    TX_IDLE  = 2'h0,
    TX_CYC   = 2'h1,
    TX_REPLY = 2'h3
  } plcm_tx_e;

  plcm_tx_e      tx_reg, tx_next;
  logic [CW-1:0] cyc_cnt_reg, cyc_cnt_next;
  logic [CW-1:0] mon_cnt_reg, mon_cnt_next;
  logic          reply_pend_reg, reply_pend_next;
  logic          fault_reg, fault_next;
  logic          ev_fault_set, ev_fault_clr, ev_tx;

  always_comb begin
    tx_next         = tx_reg;
    cyc_cnt_next    = cyc_cnt_reg;
    reply_pend_next = reply_pend_reg | rx_s; // RQ6
    ev_tx           = 1'b0;
    // A held key keeps the cyclic timer restarting, so no cyclic frame is sent while it is down.
    if (key_s || cyc_cnt_reg >= period - 1'b1) begin
      cyc_cnt_next = '0;
    end else begin
      cyc_cnt_next = cyc_cnt_reg + 1'b1;
    end
    case (tx_reg)
      TX_IDLE: begin
        if (reply_pend_reg) begin
          tx_next         = TX_REPLY; // RQ6
          reply_pend_next = rx_s;
        end else if (!key_s && cyc_cnt_reg >= period - 1'b1) begin
          tx_next = TX_CYC; // RQ4
        end
      end
      TX_CYC, TX_REPLY: begin
        if (TX_DONE) begin
          tx_next = TX_IDLE;
          ev_tx   = 1'b1;
        end
      end
      default: tx_next = TX_IDLE;
    endcase
    if (control_reg[1]) begin
      tx_next = TX_IDLE;
    end
  end

  // Receipt monitor.
  always_comb begin
    fault_next   = fault_reg;
    mon_cnt_next = mon_cnt_reg;
    if (rx_s) begin
      mon_cnt_next = '0;
      fault_next   = 1'b0; // RQ14
    end else if (mon_cnt_reg >= mon_len - 1'b1) begin
      fault_next = 1'b1; // RQ14
    end else begin
      mon_cnt_next = mon_cnt_reg + 1'b1;
    end
    ev_fault_set = fault_next & ~fault_reg;
    ev_fault_clr = fault_reg & ~fault_next;
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      tx_reg         <= TX_IDLE;
      cyc_cnt_reg    <= '0;
      mon_cnt_reg    <= '0;
      reply_pend_reg <= 1'b0;
      fault_reg      <= 1'b0;
    end else begin
      tx_reg         <= tx_next;
      cyc_cnt_reg    <= cyc_cnt_next;
      mon_cnt_reg    <= mon_cnt_next;
      reply_pend_reg <= reply_pend_next;
      fault_reg      <= fault_next;
    end
  end

  assign TX_REQ           = (tx_reg != TX_IDLE);
  assign TX_IS_REPLY      = (tx_reg == TX_REPLY);
  assign COMM_FAULT       = fault_reg;
  // The bank is taken as set, so the suggested defaults need no special logic.
  assign BAUD_FAST        = cfg.baud_fast; // RQ1 RQ9 RQ10
  assign STATION_ADDR     = cfg.station_addr; // RQ7 RQ11 RQ13
  assign CUSTOMER_VARIANT = cfg.customer_variant; // RQ8

  // Register file: one wait state on every access.
  logic [`PLCM_IRQ_W-1:0] irq_stat_reg, irq_stat_next;
  logic [`PLCM_IRQ_W-1:0] irq_mask_reg, irq_mask_next;
  logic [31:0]            rdata_reg, rdata_next;
  logic [1:0]             resp_reg, resp_next;
  logic                   ack_reg, ack_next;
  logic [`PLCM_IRQ_W-1:0] ev_vec, w1c;
  logic [7:0]             byte_addr;
  logic                   hit;
  logic                   wr_go;

  always_comb begin
    byte_addr     = {3'h0, AVS_ADDRESS};
    // Writes land only at the edge where the master sees waitrequest low.
    wr_go         = AVS_WRITE & ack_reg & AVS_BYTEENABLE[0];
    ev_vec        = {ev_tx, ev_fault_clr, ev_fault_set};
    ack_next      = (AVS_READ | AVS_WRITE) & ~ack_reg;
    rdata_next    = rdata_reg;
    resp_next     = resp_reg;
    control_next  = control_reg;
    irq_mask_next = irq_mask_reg;
    w1c           = '0;
    hit           = 1'b1;
    if (AVS_READ | AVS_WRITE) begin
      rdata_next = 32'h0;
      case (byte_addr[4:0])
        `PLCM_OFS_CONFIG: begin
          rdata_next = {24'h0, cfg.customer_variant, cfg.station_addr, cfg.cyc_sel, cfg.baud_fast};
        end
        `PLCM_OFS_STATUS: begin
          rdata_next = {27'h0, reply_pend_reg, tx_reg, fault_reg, key_s};
        end
        `PLCM_OFS_IRQ_STAT: begin
          rdata_next = {29'h0, irq_stat_reg};
          if (wr_go) w1c = AVS_WRITEDATA[`PLCM_IRQ_W-1:0];
        end
        `PLCM_OFS_IRQ_MASK: begin
          rdata_next = {29'h0, irq_mask_reg};
          if (wr_go) irq_mask_next = AVS_WRITEDATA[`PLCM_IRQ_W-1:0];
        end
        `PLCM_OFS_CONTROL: begin
          rdata_next = {30'h0, control_reg};
          if (wr_go) control_next = AVS_WRITEDATA[1:0];
        end
        default: hit = 1'b0;
      endcase
      resp_next = hit ? 2'h0 : 2'h2;
    end
    // A new event wins over a clear in the same cycle.
    irq_stat_next = (irq_stat_reg & ~w1c) | ev_vec;
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      irq_stat_reg <= '0;
      irq_mask_reg <= `PLCM_MASK_RST;
      control_reg  <= `PLCM_CONTROL_RST;
      rdata_reg    <= 32'h0;
      resp_reg     <= 2'h0;
      ack_reg      <= 1'b0;
    end else begin
      irq_stat_reg <= irq_stat_next;
      irq_mask_reg <= irq_mask_next;
      control_reg  <= control_next;
      rdata_reg    <= rdata_next;
      resp_reg     <= resp_next;
      ack_reg      <= ack_next;
    end
  end

  assign AVS_READDATA    = rdata_reg;
  assign AVS_RESPONSE    = resp_reg;
  assign AVS_WAITREQUEST = (AVS_READ | AVS_WRITE) & ~ack_reg;
  assign IRQ             = |(irq_stat_reg & irq_mask_reg);
endmodule

// *** verilog/plcm_pkg.sv ***
package plcm_pkg;
  typedef enum logic [1:0] {
    PLCM_CYC_50  = 2'h0,
    PLCM_CYC_200 = 2'h1,
    PLCM_CYC_100 = 2'h2,
    PLCM_CYC_BAD = 2'h3
  } plcm_cyc_e;
endpackage

// *** verilog/plcm_switch_sync.sv ***
`timescale 1ns/100ps
`include "plcm_consts.svh"
module plcm_switch_sync #(
  parameter int W = 8
) (
  // Clock and reset.
  input  wire logic         clk,
  input  wire logic         rst,
  // Raw switch levels.
  input  wire logic [W-1:0] sw_raw,
  // Debounced configuration.
  plcm_cfg_if.src           cfg
);
  initial begin
    if (W != 8) $error("switch bank must be eight wide");
  end

  logic [W-1:0] s1_reg, s2_reg, s3_reg, st_reg;
  logic [W-1:0] st_next;

  // A change counts only once the second and third stages agree.
  always_comb begin
    st_next = st_reg;
    for (int i = 0; i < W; i++) begin
      if (s2_reg[i] == s3_reg[i]) begin
        st_next[i] = s3_reg[i];
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
      st_reg <= '0;
    end else begin
      s1_reg <= sw_raw;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      st_reg <= st_next;
    end
  end

  assign cfg.baud_fast        = st_reg[`PLCM_SW_BAUD];
  assign cfg.cyc_sel          = {st_reg[`PLCM_SW_CYC_HI], st_reg[`PLCM_SW_CYC_LO]};
  assign cfg.station_addr     = st_reg[`PLCM_SW_ADDR_LSB +: 4];
  assign cfg.customer_variant = st_reg[`PLCM_SW_VARIANT];
endmodule
